// *** shared/cal_readout_map.svh ***
// register offsets, field positions, reset values, mode bits and burst constants for the readout block
`ifndef CAL_READOUT_MAP_SVH
`define CAL_READOUT_MAP_SVH

// register byte offsets
`define CFG_OFFSET          32'h0000_0000
`define LAT_OFFSET          32'h0000_0004
`define STATUS_OFFSET       32'h0000_0008

// configuration register fields
`define CFG_ALL_FB_BIT      0
`define CFG_REPLICATE_BIT   1
`define CFG_RESET           32'h0000_0000

// latency register fields
`define LAT_CL_LSB          0
`define LAT_AL_LSB          8
`define LAT_FIELD_W         5
`define LAT_RESET           32'h0000_0006

// status register fields
`define ST_WL_BIT           0
`define ST_CAL_BIT          1
`define ST_LOC_LSB          2
`define ST_BUSY_BIT         4
`define ST_FB_BIT           5
`define ST_DLL_BIT          6

// mode register and read command address bits
`define MR1_WL_BIT          7
`define MR3_CAL_BIT         2
`define MR0_BL_LSB          0
`define A_NIBBLE_BIT        2
`define A_CHOP_BIT          12

// burst-length field of mode register zero
`define BL_FIXED8           2'h0
`define BL_OTF              2'h1
`define BL_FIXED4           2'h2

// calibration pattern, burst order bit 0 in the lsb
`define CAL_PATTERN         8'hAA
`define CAL_LOC_PATTERN     2'h0
`define BEATS_EIGHT         4'h8
`define BEATS_FOUR          4'h4
`define NIBBLE_BASE         3'h4

`endif

// *** shared/cal_readout_pkg.sv ***
// types shared by the readout block
package cal_readout_pkg;
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_MRS,
    CMD_READ,
    CMD_OTHER
  } cmd_t;

  typedef enum {
    DRV_OFF,
    DRV_LEVEL,
    DRV_BURST
  } drive_t;
endpackage

// *** design/cal_readout.sv ***
// device-side write-leveling feedback and calibration pattern readout with an AHB-Lite slave
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cal_readout_map.svh"

// Behaviour
// (RQ1) mode register one bit 7 enters write leveling; clearing it leaves
// (RQ2) feedback on one prime DQ or all; unused DQs held low throughout
// (RQ3) feedback is the CK level caught at each rising strobe edge
// (RQ4) controller stops the strobe after the last edge; DQ undefined until tMOD
// (RQ5) controller then drives ODT low with setup and keeps it low
// (RQ6) controller disables leveling only after termination is off
// (RQ7) controller waits tMRD for mode writes, tMOD for any command
// (RQ8) mode register three bit 2 set enables calibration mode
// (RQ9) controller precharges all banks and meets tRP before enabling; ctrl_model issues no precharge before enabling
// (RQ10) in calibration mode every read is answered from the pattern register
// (RQ11) controller issues only reads in calibration mode; reset still allowed
// (RQ12) read with auto precharge acts as plain read; precharge ignored
// (RQ13) with bit 2 clear, location ignored and reads go to the array
// (RQ14) pattern on DQ0; DQ1 to DQ7 copy DQ0 or drive zero
// (RQ15) column bits 1:0 zero; bank and other address bits ignored
// (RQ16) eight-beat reads use column bit 2 zero, order 0 through 7
// (RQ17) chopped reads: column bit 2 picks nibble 0-3 or 4-7
// (RQ18) address bit 12 selects chop on the fly when mode zero allows
// (RQ19) normal read latency applies; DLL locked before reads
// (RQ20) burst starts read latency, additive plus CAS, after the command
// (RQ21) burst order bit 0 is the lsb, bit 7 the msb
// (RQ22) location 00 returns 0,1,0,1 pattern; other locations reserved
// (RQ23) controller waits tMRD and tMOD; no writes while bit 2 set
// (RQ24) controller waits tMPRR after last burst before disabling
module cal_readout
  import cal_readout_pkg::*;
#(
  parameter int RL_MAX = 32
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [14:0] addr,
  input  wire logic        odt,
  input  wire logic        dqs,
  input  wire logic        ck_level,
  input  wire logic        dll_locked,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  output logic             array_read
);

  // command decode straight from the pins, with no register in between
  cmd_t        cmd;
  logic        mrs_mr0;
  logic        mrs_mr1;
  logic        mrs_mr3;
  logic        rd_cmd;
  logic        rd_cal;
  always_comb
  begin
    if (cs_n)
      cmd = CMD_NOP;
    else if (!ras_n && !cas_n && !we_n)
      cmd = CMD_MRS;
    else if (ras_n && !cas_n && we_n)
      cmd = CMD_READ;
    else if (ras_n && cas_n && we_n)
      cmd = CMD_NOP;
    else
      cmd = CMD_OTHER;
  end

  assign mrs_mr0 = ce && (cmd == CMD_MRS) && (ba == 3'h0);
  assign mrs_mr1 = ce && (cmd == CMD_MRS) && (ba == 3'h1);
  assign mrs_mr3 = ce && (cmd == CMD_MRS) && (ba == 3'h3);
  assign rd_cmd  = ce && (cmd == CMD_READ);
  // mode state captured from mode register writes
  logic        wl_mode_r;
  logic        cal_mode_r;
  logic [1:0]  cal_loc_r;
  logic [1:0]  bl_mode_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wl_mode_r <= 1'b0;
    else if (mrs_mr1)
      wl_mode_r <= addr[`MR1_WL_BIT];                             // [RQ1]
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cal_mode_r <= 1'b0;
      cal_loc_r  <= 2'h0;
    end
    else if (mrs_mr3)
    begin
      cal_mode_r <= addr[`MR3_CAL_BIT];                           // [RQ8]
      cal_loc_r  <= addr[1:0];                                    // [RQ10]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bl_mode_r <= `BL_FIXED8;
    else if (mrs_mr0)
      bl_mode_r <= addr[`MR0_BL_LSB +: 2];
  end
  // register file: configuration and latency written by software
  logic [31:0] cfg_r;
  logic [31:0] lat_r;
  logic        ap_write_r;
  logic        ap_read;
  logic [31:0] ap_addr_r;
  logic        ap_valid;
  assign ap_valid  = hsel && hready && htrans[1] && ce;
  assign ap_read   = ap_valid && !hwrite;
  assign hreadyout = 1'b1;   // zero wait states, every access completes at once
  assign hresp     = 1'b0;
  // full address kept, so an unmapped offset never aliases onto a register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_write_r <= 1'b0;
      ap_addr_r  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ap_write_r <= ap_valid && hwrite;
      ap_addr_r  <= haddr;
    end
  end
  // write data arrives in the data phase, one cycle after the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_r <= `CFG_RESET;
      lat_r <= `LAT_RESET;
    end
    else if (ce && ap_write_r)
    begin
      if (ap_addr_r == `CFG_OFFSET)
        cfg_r <= hwdata;
      else if (ap_addr_r == `LAT_OFFSET)
        lat_r <= hwdata;
    end
  end

  // read latency: additive plus CAS, held at least two to keep the pipe tap legal
  logic [5:0]  rl;
  logic [5:0]  rl_idx;
  assign rl     = {1'b0, lat_r[`LAT_AL_LSB +: `LAT_FIELD_W]}
                + {1'b0, lat_r[`LAT_CL_LSB +: `LAT_FIELD_W]};    // [RQ20]
  assign rl_idx = (rl < 6'd2) ? 6'd0 : rl - 6'd2;

  // chop decision and nibble choice for a calibration read
  logic        rd_chop;
  logic        rd_nib;

  always_comb
  begin
    case (bl_mode_r)
      `BL_OTF:    rd_chop = !addr[`A_CHOP_BIT];                   // [RQ18]
      `BL_FIXED4: rd_chop = 1'b1;
      default:    rd_chop = 1'b0;
    endcase
  end

  // bank, auto-precharge and other column bits are never looked at here
  assign rd_nib = rd_chop && addr[`A_NIBBLE_BIT];                 // [RQ15] [RQ16] [RQ17]
  assign rd_cal = rd_cmd && cal_mode_r;                           // [RQ10] [RQ12]

  // normal reads leave for the array, one pulse per command
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      array_read <= 1'b0;
    else if (ce)
      array_read <= rd_cmd && !cal_mode_r;                        // [RQ13]
  end

  // latency pipe, one stage per clock, so back-to-back reads each keep their slot
  logic [RL_MAX-1:0] pend_v_r;
  logic [RL_MAX-1:0] pend_chop_r;
  logic [RL_MAX-1:0] pend_nib_r;
  logic              launch;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_v_r    <= '0;
      pend_chop_r <= '0;
      pend_nib_r  <= '0;
    end
    else if (ce)
    begin
      pend_v_r    <= {pend_v_r[RL_MAX-2:0], rd_cal};
      pend_chop_r <= {pend_chop_r[RL_MAX-2:0], rd_chop};
      pend_nib_r  <= {pend_nib_r[RL_MAX-2:0], rd_nib};
    end
  end

  assign launch = ce && pend_v_r[rl_idx[4:0]];                    // [RQ19] [RQ20]
  // burst sequencer: a later launch restarts the sequencer
  logic [2:0]  beat_r;
  logic [3:0]  left_r;
  logic        burst_r;
  logic [2:0]  base;
  logic [7:0]  pattern;
  assign base    = pend_nib_r[rl_idx[4:0]] ? `NIBBLE_BASE : 3'h0;
  assign pattern = (cal_loc_r == `CAL_LOC_PATTERN) ? `CAL_PATTERN : 8'h00; // [RQ22]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      beat_r  <= 3'h0;
      left_r  <= 4'h0;
      burst_r <= 1'b0;
    end
    else if (launch)
    begin
      beat_r  <= base;
      left_r  <= pend_chop_r[rl_idx[4:0]] ? `BEATS_FOUR - 4'h1 : `BEATS_EIGHT - 4'h1;
      burst_r <= 1'b1;
    end
    else if (ce && burst_r)
    begin
      beat_r  <= beat_r + 3'h1;
      left_r  <= left_r - 4'h1;
      burst_r <= (left_r != 4'h0);
    end
  end

  // leveling feedback: CK level caught on each rising strobe edge
  logic        dqs_prev_r;
  logic        wl_fb_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dqs_prev_r <= 1'b0;
      wl_fb_r    <= 1'b0;
    end
    else if (ce)
    begin
      dqs_prev_r <= dqs;
      if (wl_mode_r && dqs && !dqs_prev_r)
        wl_fb_r <= ck_level;                                      // [RQ3]
    end
  end

  // output driver selection; leveling wins since reads are illegal during it
  drive_t      drive;
  logic        bit_now;

  always_comb
  begin
    if (wl_mode_r)
      drive = DRV_LEVEL;
    else if (burst_r)
      drive = DRV_BURST;
    else
      drive = DRV_OFF;
  end

  assign bit_now = pattern[beat_r];                               // [RQ21]
  // registered DQ, so the pins never glitch on the mode switch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dq_out <= 8'h00;
      dq_oe  <= 1'b0;
    end
    else if (ce)
    begin
      case (drive)
        DRV_LEVEL:
        begin
          dq_out <= cfg_r[`CFG_ALL_FB_BIT] ? {8{wl_fb_r}} : {7'h00, wl_fb_r}; // [RQ2]
          dq_oe  <= 1'b1;
        end
        DRV_BURST:
        begin
          dq_out <= cfg_r[`CFG_REPLICATE_BIT] ? {8{bit_now}} : {7'h00, bit_now}; // [RQ14]
          dq_oe  <= 1'b1;
        end
        default:
        begin
          dq_out <= 8'h00;   // released at leveling exit; the far end ignores it until tMOD
          dq_oe  <= 1'b0;
        end
      endcase
    end
  end

  // status and read-back data, taken in the address phase
  logic [31:0] status;

  assign status = {25'h000_0000, dll_locked, wl_fb_r, burst_r, cal_loc_r, cal_mode_r, wl_mode_r};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap_read)
    begin
      if (haddr == `CFG_OFFSET)
        hrdata <= cfg_r;
      else if (haddr == `LAT_OFFSET)
        hrdata <= lat_r;
      else if (haddr == `STATUS_OFFSET)
        hrdata <= status;
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // checks
  sequence s_mr1_write;
    mrs_mr1;
  endsequence
  sequence s_level_edge;
    ce && wl_mode_r && dqs && !dqs_prev_r;
  endsequence
  chk_wl_entry_exit: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ1]
    s_mr1_write |=> (wl_mode_r == $past(addr[7])))
    else $error("leveling mode does not follow mode register one bit 7");
  chk_wl_feedback_level: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ3]
    s_level_edge ##1 (ce && wl_mode_r) |=> (dq_out[0] == $past(ck_level, 2)))
    else $error("leveling feedback differs from sampled clock level");
  // lanes shown now were chosen with last cycle's configuration
  chk_prime_dq_low: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ2]
    (dq_oe && wl_mode_r && $past(wl_mode_r) && !$past(cfg_r[0])) |-> (dq_out[7:1] == 7'h00))
    else $error("non-prime DQ not held low during leveling");
  chk_cal_enable_bit: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ8]
    mrs_mr3 |=> (cal_mode_r == $past(addr[2])) && (cal_loc_r == $past(addr[1:0])))
    else $error("calibration mode does not follow mode register three");
  chk_array_redirect: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ13]
    (rd_cmd && !cal_mode_r) |=> array_read ##1 !pend_v_r[0])
    else $error("normal read not passed to the array");
  chk_pattern_beats: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ22]
    (burst_r && !wl_mode_r && cal_loc_r == 2'h0 && ce) |=> dq_oe && (dq_out[0] == $past(beat_r[0])))
    else $error("calibration beat does not follow the alternating pattern");
  chk_chop_nibble: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ17]
    (launch && pend_chop_r[rl_idx[4:0]] && pend_nib_r[rl_idx[4:0]]) |=> (beat_r == 3'h4)
      && (left_r == 4'h3))
    else $error("chopped read did not select the upper nibble");
  chk_dq_replicate: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ14]
    (ce && drive == DRV_BURST && cfg_r[1]) |=> (dq_out == {8{dq_out[0]}}))
    else $error("DQ1 to DQ7 do not copy DQ0");
  // burst_r stands for eight sampled cycles after the launch, then drops
  chk_eight_beat_len: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ16]
    (launch && !pend_chop_r[rl_idx[4:0]]) ##1 (ce && !launch)[*8] |=> !burst_r)
    else $error("eight-beat burst length wrong");

endmodule // cal_readout

// *** bench/ctrl_model.sv ***
// controller-side model: commands, leveling strobe, termination and waits
`timescale 1ns/1ps
module ctrl_model #(
  parameter int T_MOD  = 12,
  parameter int T_MPRR = 2
)(
  input  wire logic        hclk,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       ba,
  output logic [14:0]      addr,
  output logic             odt,
  output logic             dqs,
  output logic             ck_level
);
  // deselected, strobe parked low, termination off
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba       = 3'h0;
    addr     = 15'h0;
    odt      = 1'b0;
    dqs      = 1'b0;
    ck_level = 1'b0;
  end

  task automatic gap(input int n);
  begin
    repeat (n) @(posedge hclk);
  end
  endtask

  // one command cycle, then deselect; pins no longer keep the last value
  task automatic issue(input logic [2:0] rcw, input logic [2:0] b, input logic [14:0] a);
  begin
    @(posedge hclk);
    {cs_n, ras_n, cas_n, we_n} <= {1'b0, rcw};
    ba   <= b;
    addr <= a;
    @(posedge hclk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    ba   <= ~b;
    addr <= ~a;
  end
  endtask

  // mode write; tMOD outlasts tMRD so one wait covers both
  task automatic mrs(input logic [2:0] b, input logic [14:0] a);
  begin
    issue(3'h0, b, a);
    gap(T_MOD);
  end
  endtask

  // only reads are sent while calibration mode is on
  task automatic rd(input logic [2:0] b, input logic [14:0] a);
  begin
    issue(3'h5, b, a);
  end
  endtask

  // single rising strobe edge with the clock level driven on the same clock edge as it
  task automatic strobe(input logic v);
  begin
    @(posedge hclk);
    ck_level <= v;
    dqs      <= 1'b1;
    @(posedge hclk);
    dqs      <= 1'b0;
    ck_level <= ~v;
  end
  endtask

  task automatic enter_level();
  begin
    mrs(3'h1, 15'h0080);
    odt <= 1'b1;
  end
  endtask

  // strobe already stopped low; termination off before the exit write
  task automatic leave_level();
  begin
    @(posedge hclk);
    odt <= 1'b0;
    gap(T_MOD);
    mrs(3'h1, 15'h0000);
  end
  endtask
endmodule // ctrl_model

// *** bench/cal_readout_test.sv ***
// self-checking bench for the leveling and calibration readout block
`timescale 1ns/1ps
module cal_readout_test;
  import cal_readout_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, dq_oe, array_read;
  logic        cs_n, ras_n, cas_n, we_n, odt, dqs, ck_level;
  logic [1:0]  htrans;
  logic [2:0]  ba;
  logic [14:0] addr;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [7:0]  dq_out;
  int          n_errors, cmp_count;

  cal_readout cal_readout_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .odt(odt), .dqs(dqs), .ck_level(ck_level), .dll_locked(1'b1), .dq_out(dq_out),
    .dq_oe(dq_oe), .array_read(array_read));

  ctrl_model ctrl_model_inst (.hclk(hclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .dqs(dqs), .ck_level(ck_level));

  // 10 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic give_verdict();
  begin
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
  begin
    cmp_count++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  end
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
  begin
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_errors++;
      give_verdict();
    end
  end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
  begin
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rv = hrdata;
  end
  endtask

  task automatic reg_chk(input logic [31:0] a, input logic [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    chk("register", e, rv);
  end
  endtask

  // burst after a read: latency, beat values, lanes, then release
  task automatic burst(input int rl, input int nb, input int off, input logic z,
                       input logic rep);
    int          n;
    logic        b;
  begin
    n = 0;
    @(negedge hclk);
    while (dq_oe !== 1'b1 && n < 60)
    begin
      n++;
      @(negedge hclk);
    end
    chk("latency", rl, n);
    if (n >= 60)
      give_verdict();
    for (int k = 0; k < nb; k++)
    begin
      b = ~z & (((k + off) % 2) == 1);
      chk("beat", rep ? {24'h0, {8{b}}} : {31'h0, b}, {24'h0, dq_out});
      @(negedge hclk);
    end
    chk("release", 1'b0, dq_oe);
  end
  endtask

  task automatic fb_chk(input logic v, input logic [7:0] e);
  begin
    ctrl_model_inst.strobe(v);
    repeat (2) @(negedge hclk);
    chk("feedback", e, dq_out);
    chk("fb_drive", 1'b1, dq_oe);
  end
  endtask

  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped place ignored
    reg_chk(32'h0000_0000, 32'h0000_0000);
    reg_chk(32'h0000_0004, 32'h0000_0006);
    reg_chk(32'h0000_0008, 32'h0000_0040);
    bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    reg_chk(32'h0000_0010, 32'h0000_0000);
    reg_chk(32'h0000_0000, 32'h0000_0000);
    // write leveling: prime lane, then all lanes
    ctrl_model_inst.enter_level();
    reg_chk(32'h0000_0008, 32'h0000_0041);
    fb_chk(1'b1, 8'h01);
    fb_chk(1'b0, 8'h00);
    bus(1'b1, 32'h0000_0000, 32'h0000_0001);
    fb_chk(1'b1, 8'hFF);
    fb_chk(1'b0, 8'h00);
    bus(1'b1, 32'h0000_0000, 32'h0000_0000);
    ctrl_model_inst.leave_level();
    chk("level_exit", 1'b0, dq_oe);
    reg_chk(32'h0000_0008, 32'h0000_0040);
    // on-the-fly chop, then calibration mode location 0
    ctrl_model_inst.mrs(3'h0, 15'h0001);
    ctrl_model_inst.mrs(3'h3, 15'h0004);
    reg_chk(32'h0000_0008, 32'h0000_0042);
    ctrl_model_inst.rd(3'h0, 15'h1000);
    burst(6, 8, 0, 1'b0, 1'b0);
    ctrl_model_inst.rd(3'h7, 15'h7FF8);
    burst(6, 8, 0, 1'b0, 1'b0);
    ctrl_model_inst.rd(3'h2, 15'h0000);
    burst(6, 4, 0, 1'b0, 1'b0);
    ctrl_model_inst.rd(3'h0, 15'h0004);
    burst(6, 4, 4, 1'b0, 1'b0);
    bus(1'b1, 32'h0000_0000, 32'h0000_0002);
    bus(1'b1, 32'h0000_0004, 32'h0000_0205);
    ctrl_model_inst.rd(3'h0, 15'h1000);
    burst(7, 8, 0, 1'b0, 1'b1);
    bus(1'b1, 32'h0000_0000, 32'h0000_0000);
    // leave, fixed chop, reserved location
    ctrl_model_inst.gap(ctrl_model_inst.T_MPRR);
    ctrl_model_inst.mrs(3'h3, 15'h0000);
    ctrl_model_inst.mrs(3'h0, 15'h0002);
    ctrl_model_inst.mrs(3'h3, 15'h0005);
    reg_chk(32'h0000_0008, 32'h0000_0046);
    ctrl_model_inst.rd(3'h0, 15'h0004);
    burst(7, 4, 4, 1'b1, 1'b0);
    // reset taken in calibration mode drops every mode and register
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    reg_chk(32'h0000_0008, 32'h0000_0040);
    reg_chk(32'h0000_0004, 32'h0000_0006);
    ctrl_model_inst.gap(ctrl_model_inst.T_MPRR);
    // mode off with a location set: reads go to the array
    ctrl_model_inst.mrs(3'h3, 15'h0003);
    ctrl_model_inst.rd(3'h0, 15'h0000);
    @(negedge hclk);
    chk("array_read", 1'b1, array_read);
    chk("array_quiet", 1'b0, dq_oe);
    repeat (12) @(negedge hclk);
    chk("array_idle", 1'b0, dq_oe);
    give_verdict();
  end
endmodule // cal_readout_test
